// *** hdl/odt_pd_ctrl.sv ***
`default_nettype none
// Notes on behaviour
// - Uncertain flag only when DLL-off select is 0; entry/exit window outputs regardless.
// - Entry period: greater of anticipation, refresh recovery.
// - Exit period: anticipation plus DLL-off exit time.
// - Anticipation delay is write latency minus one.
// - Sync turn-on/off latency is write latency minus two.
// - Turn-on bounds: lesser/greater of async and sync.
// - Turn-off bounds: lesser/greater of async and sync.
// - After exit period, termination answers synchronously.
// - Short CKE low: uncertain from entry to exit end.
// - Short CKE high: uncertain from exit to entry end.
// - Entry ends at CKE low or refresh recovery.
// - Async termination skips additive latency.
module odt_pd_ctrl #(
    parameter int CAS_WRITE_LATENCY         = 5,
    parameter int AL          = 0,
    parameter int XPDLL_CK    = 10,
    parameter int RFC_CK      = 64,
    parameter int AON_SKEW_PS = 250
) (
    // Clock and reset.
    input  wire logic           clk_sys_i,
    input  wire logic           nrst_i,
    // Requests from the scheduler.
    input  wire logic           pd_req_i,
    input  wire logic           odt_req_i,
    input  wire logic           refresh_req_i,
    input  wire logic           dll_powerdown_select_bit_i,
    // Window status.
    output logic                uncertain_o,
    output logic                entry_window_o,
    output logic                exit_window_o,
    output logic                powered_down_o,
    output logic                refresh_busy_o,
    output logic                term_sense_o,
    // Termination change bounds in picoseconds.
    output logic [31:0]         on_early_ps_o,
    output logic [31:0]         on_late_ps_o,
    output logic [31:0]         off_early_ps_o,
    output logic [31:0]         off_late_ps_o,
    // Link to the device.
    odt_link_if.ctrl            link
);
    import odt_pd_pkg::*;

    localparam int WL          = CAS_WRITE_LATENCY + AL;
    localparam int SYNC_LAT    = WL - SYNC_LAT_OFFSET;
    localparam int ANTIC_A     = SYNC_LAT + ANTIC_OFFSET;
    localparam int ANTIC_CK    = (ANTIC_A > WL - ANTIC_OFFSET) ? ANTIC_A
                                 : WL - ANTIC_OFFSET;
    localparam int SYNC_PS     = SYNC_LAT * LINK_TCK_PS;
    localparam int ON_MIN_S    = SYNC_PS - AON_SKEW_PS;
    localparam int ON_MAX_S    = SYNC_PS + AON_SKEW_PS;
    localparam int OFF_MIN_S   = SYNC_PS + (SYNC_OFF_SKEW_MIN_D * LINK_TCK_PS) / 10;
    localparam int OFF_MAX_S   = SYNC_PS + (SYNC_OFF_SKEW_MAX_D * LINK_TCK_PS) / 10;
    localparam int ON_EARLY    = (ASYNC_TERM_MIN_PS < ON_MIN_S) ? ASYNC_TERM_MIN_PS
                                 : ON_MIN_S;
    localparam int ON_LATE     = (ASYNC_TERM_MAX_PS > ON_MAX_S) ? ASYNC_TERM_MAX_PS
                                 : ON_MAX_S;
    localparam int OFF_EARLY   = (ASYNC_TERM_MIN_PS < OFF_MIN_S) ? ASYNC_TERM_MIN_PS
                                 : OFF_MIN_S;
    localparam int OFF_LATE    = (ASYNC_TERM_MAX_PS > OFF_MAX_S) ? ASYNC_TERM_MAX_PS
                                 : OFF_MAX_S;

    typedef struct packed {
        logic             ck;
        logic [CNT_W-1:0] div;
        pd_state_t        st;
        logic [CNT_W-1:0] cnt;
        logic             entry;
        logic             cke;
        logic             odt;
        logic             refresh;
        logic             ref_pend;
        logic [CNT_W-1:0] rfc_cnt;
        logic             uncertain;
        logic             dll_sel;
        logic             sense_meta;
        logic             sense;
        logic [31:0]      on_early;
        logic [31:0]      on_late;
        logic [31:0]      off_early;
        logic [31:0]      off_late;
    } ctrl_st_t;

    ctrl_st_t s;
    ctrl_st_t next_s;
    logic     ck_fall;
    logic     rfc_tail;
    logic     busy;

    always_comb begin
        next_s  = s;
        ck_fall = 1'b0;

        // Link clock divider; all link outputs move on the falling edge so the
        // device, which samples on the rising edge, sees half a period of setup.
        if (s.div == CNT_W'(CK_HALF_SYS - 1)) begin
            next_s.div = CNT_ZERO;
            next_s.ck  = ~s.ck;
            ck_fall    = s.ck;
        end else begin
            next_s.div = s.div + 8'h01;
        end

        // A refresh request is held until the next link edge can issue it.
        if (refresh_req_i) begin
            next_s.ref_pend = 1'b1;
        end

        // The term sense comes from the link domain, so it is synchronised.
        next_s.sense_meta = link.term_on;
        next_s.sense      = s.sense_meta;

        next_s.on_early  = 32'(ON_EARLY);
        next_s.on_late   = 32'(ON_LATE);
        next_s.off_early = 32'(OFF_EARLY);
        next_s.off_late  = 32'(OFF_LATE);

        if (ck_fall) begin
            next_s.odt     = odt_req_i;
            next_s.dll_sel = dll_powerdown_select_bit_i;
            next_s.refresh = 1'b0;
            if (s.rfc_cnt != CNT_ZERO) begin
                next_s.rfc_cnt = s.rfc_cnt - 8'h01;
            end
            // Refresh is issued only with CKE high and no refresh running.
            if ((s.ref_pend || refresh_req_i) && s.cke && s.st != ST_ANTIC &&
                s.rfc_cnt == CNT_ZERO) begin
                next_s.refresh  = 1'b1;
                next_s.ref_pend = 1'b0;
                next_s.rfc_cnt  = CNT_W'(RFC_CK);
            end

            case (s.st)
                ST_STEADY: begin
                    if (pd_req_i == s.cke) begin
                        // CKE is held for one anticipation delay before it moves.
                        next_s.st    = ST_ANTIC;
                        next_s.cnt   = CNT_W'(ANTIC_CK - 1);
                        next_s.entry = s.cke;
                    end
                end
                ST_ANTIC: begin
                    if (s.cnt != CNT_ZERO) begin
                        next_s.cnt = s.cnt - 8'h01;
                    end else begin
                        next_s.cke = ~s.cke;
                        next_s.st  = ST_TAIL;
                        if (s.entry) begin
                            next_s.cnt = CNT_ZERO;
                        end else begin
                            next_s.cnt = CNT_W'(XPDLL_CK);
                        end
                    end
                end
                ST_TAIL: begin
                    if (pd_req_i == s.cke) begin
                        // A new transition before this one ends keeps the flag up.
                        next_s.st    = ST_ANTIC;
                        next_s.cnt   = CNT_W'(ANTIC_CK - 1);
                        next_s.entry = s.cke;
                    end else if (s.cnt != CNT_ZERO) begin
                        next_s.cnt = s.cnt - 8'h01;
                    end else begin
                        next_s.st = ST_STEADY;
                    end
                end
                default: begin
                    next_s.st = ST_STEADY;
                end
            endcase
        end

        // Entry lasts past CKE low while a refresh started before it runs on.
        rfc_tail = !s.cke && (s.rfc_cnt != CNT_ZERO);
        busy     = (s.st != ST_STEADY) || rfc_tail;
        next_s.uncertain = busy && (s.dll_sel == DLL_OFF);
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s         <= '0;
            s.cke     <= CKE_RESET;
            s.dll_sel <= DLL_OFF;
            s.st      <= ST_STEADY;
        end else begin
            s <= next_s;
        end
    end

    assign link.ck        = s.ck;
    assign link.cke       = s.cke;
    assign link.odt       = s.odt;
    assign link.refresh   = s.refresh;
    assign link.dll_sel   = s.dll_sel;

    assign uncertain_o    = s.uncertain;
    assign entry_window_o = (s.st != ST_STEADY && s.entry) || (!s.cke && s.rfc_cnt != CNT_ZERO);
    assign exit_window_o  = s.st != ST_STEADY && !s.entry;
    assign powered_down_o = !s.cke;
    assign refresh_busy_o = s.rfc_cnt != CNT_ZERO;
    assign term_sense_o   = s.sense;
    assign on_early_ps_o  = s.on_early;
    assign on_late_ps_o   = s.on_late;
    assign off_early_ps_o = s.off_early;
    assign off_late_ps_o  = s.off_late;
endmodule : odt_pd_ctrl
`default_nettype wire

// *** shared/odt_pd_pkg.sv ***
`default_nettype none
package odt_pd_pkg;
    // Asynchronous termination delays in power-down with the DLL off.
    localparam int ASYNC_TERM_MIN_PS   = 2000;
    localparam int ASYNC_TERM_MAX_PS   = 8500;
    // Controller clock period as the bench makes it, and a link period shorter than the LINK_TCK_PS the divider gives.
    localparam int SYS_PERIOD_PS       = 20000;
    localparam int LINK_PERIOD_PS      = 64000;
    // Least delay rounds up, longest delay rounds down, neither below one cycle.
    localparam int ASYNC_MIN_CK_RAW    = (ASYNC_TERM_MIN_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int ASYNC_MIN_CK        = (ASYNC_MIN_CK_RAW < 1) ? 1 : ASYNC_MIN_CK_RAW;
    localparam int ASYNC_MAX_CK_RAW    = ASYNC_TERM_MAX_PS / LINK_PERIOD_PS;
    localparam int ASYNC_MAX_CK        = (ASYNC_MAX_CK_RAW < 1) ? 1 : ASYNC_MAX_CK_RAW;
    // Write latency offsets.
    localparam int SYNC_LAT_OFFSET     = 2;
    localparam int ANTIC_OFFSET        = 1;
    // Synchronous turn-off skew in tenths of a link clock.
    localparam int SYNC_OFF_SKEW_MIN_D = 3;
    localparam int SYNC_OFF_SKEW_MAX_D = 7;
    // Divider: system cycles per half period of the generated link clock.
    localparam int CK_HALF_SYS         = 2;
    localparam int LINK_TCK_PS         = 2 * CK_HALF_SYS * SYS_PERIOD_PS;
    // Counter width and reset values.
    localparam int CNT_W               = 8;
    localparam logic [7:0] CNT_ZERO    = 8'h00;
    localparam logic       CKE_RESET   = 1'b0;
    localparam logic       DLL_OFF     = 1'b0;

    typedef enum logic [1:0] {
        ST_STEADY = 2'b00,
        ST_ANTIC  = 2'b01,
        ST_TAIL   = 2'b10
    } pd_state_t;
endpackage : odt_pd_pkg
`default_nettype wire

// *** shared/odt_link_if.sv ***
`default_nettype none
interface odt_link_if;
    logic ck;
    logic cke;
    logic odt;
    logic refresh;
    logic dll_sel;
    logic term_on;

    modport ctrl (
        output ck,
        output cke,
        output odt,
        output refresh,
        output dll_sel,
        input  term_on
    );

    modport dram (
        input  ck,
        input  cke,
        input  odt,
        input  refresh,
        input  dll_sel,
        output term_on
    );
endinterface : odt_link_if
`default_nettype wire

// *** hdl/dram_odt_term.sv ***
`default_nettype none
module dram_odt_term #(
    parameter int CAS_WRITE_LATENCY      = 5,
    parameter int AL       = 0,
    parameter int XPDLL_CK = 10
) (
    // Link to the controller, clocked by the link clock.
    odt_link_if.dram            link,
    // Reset.
    input  wire logic           nrst_i,
    // User side.
    output logic                term_on_o,
    output logic                async_mode_o
);
    import odt_pd_pkg::*;

    localparam int LAT = CAS_WRITE_LATENCY + AL - SYNC_LAT_OFFSET;

    typedef struct packed {
        logic             cke;
        logic [LAT-1:0]   pipe;
        logic [CNT_W-1:0] exit_cnt;
        logic             apipe;
        logic             async_m;
        logic             term;
    } dram_st_t;

    dram_st_t s;
    dram_st_t next_s;
    logic     async_now;

    always_comb begin
        next_s     = s;
        next_s.cke = link.cke;
        // Analog path: two link edges, without the additive latency.
        next_s.apipe = link.odt;
        next_s.pipe  = {s.pipe[LAT-2:0], link.odt};
        if (s.cke == 1'b0 && link.cke == 1'b1) begin
            next_s.exit_cnt = CNT_W'(XPDLL_CK);
        end else if (s.exit_cnt != CNT_ZERO) begin
            next_s.exit_cnt = s.exit_cnt - 8'h01;
        end
        // Async only with the DLL off, in power-down and until exit has run out.
        async_now = (link.dll_sel == DLL_OFF) &&
                    (!s.cke || s.exit_cnt != CNT_ZERO);
        next_s.async_m = async_now;
        if (async_now) begin
            next_s.term = s.apipe;
        end else begin
            next_s.term = s.pipe[LAT-1];
        end
    end

    always_ff @(posedge link.ck or negedge nrst_i) begin
        if (!nrst_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign link.term_on = s.term;
    assign term_on_o    = s.term;
    assign async_mode_o = s.async_m;
endmodule : dram_odt_term
`default_nettype wire

// *** verification/odt_link_assertions.sv ***
`default_nettype none
module odt_link_assertions (
    // Link signals.
    input wire logic ck,
    input wire logic cke,
    input wire logic odt,
    input wire logic refresh,
    input wire logic dll_sel,
    input wire logic term_on,
    // Reset.
    input wire logic nrst_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ck); endclocking
    default disable iff (!nrst_i);

    property p_ref_cke; refresh |-> cke; endproperty
    a_ref_cke: assert property (p_ref_cke)
        else $error("refresh issued with cke low");
    property p_ref_pulse; $rose(refresh) |=> !refresh; endproperty
    a_ref_pulse: assert property (p_ref_pulse)
        else $error("refresh longer than one link cycle");
    property p_cke_hold; $changed(cke) |=> $stable(cke)[*3]; endproperty
    a_cke_hold: assert property (p_cke_hold)
        else $error("cke toggled inside the anticipation delay");
    // Sync answers must not come early, so the low run is part of the property.
    property p_sync_on; dll_sel && $rose(odt) && !term_on |-> !term_on[*3] ##[1:3] term_on;
    endproperty
    a_sync_on: assert property (p_sync_on)
        else $error("sync turn-on latency wrong");
    property p_sync_off; dll_sel && $fell(odt) && term_on |-> term_on[*3] ##[1:3] !term_on;
    endproperty
    a_sync_off: assert property (p_sync_off)
        else $error("sync turn-off latency wrong");
    property p_async_on; !dll_sel && !cke && !$past(cke) && $rose(odt) |-> ##[1:2] term_on;
    endproperty
    a_async_on: assert property (p_async_on)
        else $error("async turn-on too slow");
    property p_async_off; !dll_sel && !cke && !$past(cke) && $fell(odt) |-> ##[1:2] !term_on;
    endproperty
    a_async_off: assert property (p_async_off)
        else $error("async turn-off too slow");
    property p_term_cause; $changed(term_on) |-> term_on == $past(odt); endproperty
    a_term_cause: assert property (p_term_cause)
        else $error("termination changed without odt");

    c_async: cover property (!dll_sel && !cke && $rose(odt));
    c_refresh: cover property ($rose(refresh));
    c_exit: cover property (!dll_sel && $rose(cke));
endmodule : odt_link_assertions
`default_nettype wire

// *** verification/odt_powerdown_transition_tracker_test.sv ***
`default_nettype none
module odt_powerdown_transition_tracker_test import odt_pd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAT = 5 + 0 - SYNC_LAT_OFFSET;
    localparam int ANT = 5 + 0 - ANTIC_OFFSET;
    localparam int XP = 10;
    localparam int SYN = LAT * LINK_TCK_PS;
    localparam int TQ = LINK_TCK_PS / 10;
    logic        clk_sys_i = 1'b0, nrst_i = 1'b1, pd = 1'b0, odt = 1'b0, rq = 1'b0, dll = 1'b0;
    logic        unc, pdn, rbusy, sense, ew, xw, dt, am;
    logic [31:0] on_e, on_l, off_e, off_l;
    int          num_errors = 0, checks = 0, cycles = 0, n;

    odt_link_if link ();
    odt_pd_ctrl #(.CAS_WRITE_LATENCY(5), .AL(0), .XPDLL_CK(XP), .RFC_CK(8), .AON_SKEW_PS(250)) odt_pd_ctrl_inst (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pd_req_i(pd), .odt_req_i(odt),
        .refresh_req_i(rq), .dll_powerdown_select_bit_i(dll), .uncertain_o(unc),
        .entry_window_o(ew), .exit_window_o(xw), .powered_down_o(pdn), .refresh_busy_o(rbusy),
        .term_sense_o(sense), .on_early_ps_o(on_e), .on_late_ps_o(on_l),
        .off_early_ps_o(off_e), .off_late_ps_o(off_l), .link(link));
    dram_odt_term #(.CAS_WRITE_LATENCY(5), .AL(0), .XPDLL_CK(XP)) dram_odt_term_inst (
        .link(link), .nrst_i(nrst_i), .term_on_o(dt), .async_mode_o(am));
    odt_link_assertions odt_link_assertions_inst (.ck(link.ck), .cke(link.cke), .odt(link.odt),
        .refresh(link.refresh), .dll_sel(link.dll_sel), .term_on(link.term_on), .nrst_i(nrst_i));

    initial begin
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    function automatic int mn(input int a, input int b);
        return (a < b) ? a : b;
    endfunction : mn
    function automatic int mx(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : mx
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask : cyc
    // Bounded wait; the cycle count lets callers judge how long a period lasted.
    task automatic wait_lvl(ref logic s, input logic v, output int k);
        for (k = 0; k < 300 && s !== v; k++) cyc(1);
        if (s !== v) begin
            num_errors++;
            $display("[ERR] wait level expected %0h seen %0h", v, s);
        end
    endtask : wait_lvl
    // Counts cycles with the flag low while the power state stays at one level.
    task automatic hold(input logic lvl, output int lo);
        lo = 0;
        for (int i = 0; i < 300 && pdn === lvl; i++) begin
            lo += (unc !== 1'b1);
            cyc(1);
        end
    endtask : hold
    task automatic results();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            results();
        end
    end

    task automatic t_bounds();
        chk("on_early", on_e, 32'(mn(ASYNC_TERM_MIN_PS, SYN - 250)));
        chk("on_late", on_l, 32'(mx(ASYNC_TERM_MAX_PS, SYN + 250)));
        chk("off_early", off_e, 32'(mn(ASYNC_TERM_MIN_PS, SYN + SYNC_OFF_SKEW_MIN_D * TQ)));
        chk("off_late", off_l, 32'(mx(ASYNC_TERM_MAX_PS, SYN + SYNC_OFF_SKEW_MAX_D * TQ)));
        $display("test bounds done");
    endtask : t_bounds
    task automatic t_entry_async();
        pd = 1'b1;
        wait_lvl(unc, 1'b1, n);
        chk("pdn_in_antic", pdn, 1'b0);
        chk("entry_win", ew, 1'b1);
        chk("exit_win_idle", xw, 1'b0);
        wait_lvl(pdn, 1'b1, n);
        chk("antic_len", 32'((n + 2) / 4), 32'(ANT));
        chk("unc_at_entry", unc, 1'b1);
        cyc(12);
        chk("unc_after_entry", unc, 1'b0);
        chk("async_mode", am, 1'b1);
        odt = 1'b1;
        wait_lvl(sense, 1'b1, n);
        chk("async_on", 32'(n <= 14), 32'h1);
        chk("dev_term_on", dt, 1'b1);
        odt = 1'b0;
        wait_lvl(sense, 1'b0, n);
        chk("async_off", 32'(n <= 14), 32'h1);
        // Termination is left on so that the exit test sees a synchronous turn-off.
        odt = 1'b1;
        wait_lvl(sense, 1'b1, n);
        $display("test entry done");
    endtask : t_entry_async
    task automatic t_exit_sync();
        pd = 1'b0;
        wait_lvl(pdn, 1'b0, n);
        chk("unc_at_exit", unc, 1'b1);
        chk("exit_win", xw, 1'b1);
        wait_lvl(unc, 1'b0, n);
        chk("exit_tail", 32'(n >= XP * 4 && n <= XP * 4 + 6), 32'h1);
        chk("exit_win_end", xw, 1'b0);
        odt = 1'b0;
        wait_lvl(sense, 1'b0, n);
        chk("sync_off", 32'(n >= 16 && n <= 26), 32'h1);
        chk("async_mode_off", am, 1'b0);
        chk("dev_term_off", dt, 1'b0);
        $display("test exit done");
    endtask : t_exit_sync
    task automatic t_short();
        pd = 1'b1;
        wait_lvl(pdn, 1'b1, n);
        pd = 1'b0;
        hold(1'b1, n);
        chk("short_low_gap", n, 0);
        pd = 1'b1;
        hold(1'b0, n);
        chk("short_high_gap", n, 0);
        pd = 1'b0;
        wait_lvl(pdn, 1'b0, n);
        wait_lvl(unc, 1'b0, n);
        $display("test short done");
    endtask : t_short
    task automatic t_refresh();
        rq = 1'b1;
        wait_lvl(rbusy, 1'b1, n);
        rq = 1'b0;
        pd = 1'b1;
        wait_lvl(pdn, 1'b1, n);
        chk("busy_at_entry", rbusy, 1'b1);
        cyc(6);
        chk("entry_win_refresh", ew, 1'b1);
        wait_lvl(rbusy, 1'b0, n);
        chk("unc_in_recovery", unc, 1'b1);
        chk("entry_win_end", ew, 1'b0);
        cyc(8);
        chk("unc_after_recovery", unc, 1'b0);
        pd = 1'b0;
        wait_lvl(pdn, 1'b0, n);
        wait_lvl(unc, 1'b0, n);
        $display("test refresh done");
    endtask : t_refresh
    task automatic t_dll_on();
        dll = 1'b1;
        cyc(8);
        pd = 1'b1;
        wait_lvl(pdn, 1'b1, n);
        chk("unc_dll_on", unc, 1'b0);
        odt = 1'b1;
        wait_lvl(sense, 1'b1, n);
        chk("sync_on_dll_on", 32'(n >= 16), 32'h1);
        chk("async_mode_dll_on", am, 1'b0);
        odt = 1'b0;
        wait_lvl(sense, 1'b0, n);
        chk("sync_off_dll_on", 32'(n >= 16), 32'h1);
        pd = 1'b0;
        wait_lvl(pdn, 1'b0, n);
        chk("unc_dll_on_exit", unc, 1'b0);
        $display("test dll on done");
    endtask : t_dll_on

    initial begin
        // The link end is clocked only by the link clock, so it needs a real falling edge.
        #1;
        nrst_i = 1'b0;
        cyc(2);
        nrst_i = 1'b1;
        wait_lvl(pdn, 1'b0, n);
        wait_lvl(unc, 1'b0, n);
        t_bounds();
        t_entry_async();
        t_exit_sync();
        t_short();
        t_refresh();
        t_dll_on();
        results();
    end
endmodule : odt_powerdown_transition_tracker_test
`default_nettype wire
